/* verilog/adc_post_pkg.sv */
package adc_post_pkg;

  // Widths
  localparam int SAMPLE_W = 14;
  localparam int THR_W    = 13;
  localparam int DWELL_W  = 16;
  localparam int NULL_W   = 16;
  localparam int ADDR_W   = 13;
  localparam int ACC_W    = 48;

  // Register offsets
  localparam logic [12:0] ADDR_CHAN_INDEX  = 13'h0005;
  localparam logic [12:0] ADDR_OUT_FORMAT  = 13'h0014;
  localparam logic [12:0] ADDR_NULL_CTRL   = 13'h0040;
  localparam logic [12:0] ADDR_NULL_VAL_LO = 13'h0041;
  localparam logic [12:0] ADDR_NULL_VAL_HI = 13'h0042;
  localparam logic [12:0] ADDR_DETECT_CTRL = 13'h0045;
  localparam logic [12:0] ADDR_UPPER_LO    = 13'h0047;
  localparam logic [12:0] ADDR_UPPER_HI    = 13'h0048;
  localparam logic [12:0] ADDR_LOWER_LO    = 13'h0049;
  localparam logic [12:0] ADDR_LOWER_HI    = 13'h004A;
  localparam logic [12:0] ADDR_DWELL_LO    = 13'h004B;
  localparam logic [12:0] ADDR_DWELL_HI    = 13'h004C;

  // Field positions
  localparam int DETECT_EN_BIT   = 0;
  localparam int NULL_EN_BIT     = 1;
  localparam int NULL_K_LSB      = 2;
  localparam int NULL_K_MSB      = 5;
  localparam int NULL_FREEZE_BIT = 6;
  localparam int FORMAT_TWOS_BIT = 0;
  localparam int CHAN_B_BIT      = 1;

  // Reset values
  localparam logic [7:0] RST_OUT_FORMAT = 8'h01;
  localparam logic [7:0] RST_CHAN_INDEX = 8'h03;
  localparam logic [7:0] RST_ZERO       = 8'h00;

  // Timing and filter constants
  localparam int          UPPER_LATENCY = 7;
  localparam int          OVR_LATENCY   = 36;
  localparam logic [4:0]  NULL_K_BASE   = 5'h0E;
  localparam int          NULL_FRAC     = 28;
  localparam int          INSTR_BITS    = 16;

  typedef enum logic [1:0] {
    SPI_INSTR,
    SPI_DATA,
    SPI_DONE
  } spi_state_t;

endpackage

/* verilog/sample_channel.sv */
`timescale 1ns/1ns
module sample_channel (
  input  wire logic        clock_i,
  input  wire logic        rst_n_i,
  input  wire logic [13:0] sample_i,
  input  wire logic        overrange_i,
  input  wire logic        detect_enable_i,
  input  wire logic [12:0] upper_thr_i,
  input  wire logic [12:0] lower_thr_i,
  input  wire logic [15:0] dwell_i,
  input  wire logic        null_enable_i,
  input  wire logic        null_freeze_i,
  input  wire logic [3:0]  null_k_i,
  input  wire logic        twos_comp_i,
  output logic      [13:0] data_o,
  output logic             overrange_o,
  output logic             indicator_o,
  output logic      [15:0] null_value_o
);

  localparam int PIPE = adc_post_pkg::UPPER_LATENCY - 1;
  localparam int OVR  = adc_post_pkg::OVR_LATENCY;

  logic signed [13:0] x;
  logic        [13:0] mag;
  logic        [13:0] mag_pipe_reg [PIPE];
  logic        [13:0] mag_d;
  logic        [15:0] dwell_cnt_reg;
  logic        [16:0] dwell_inc;
  logic    [OVR-1:0]  ovr_pipe_reg;
  logic signed [47:0] acc_reg;
  logic signed [47:0] target;
  logic signed [47:0] step;
  logic        [4:0]  null_shift;
  logic signed [13:0] dc_int;
  logic signed [14:0] corr;
  logic signed [13:0] corr_sat;
  logic        [13:0] out_word;

  // Sign is dropped: equal excursions either way look the same
  // magnitude only
  assign x   = signed'(sample_i);
  assign mag = x[13] ? 14'(-x) : 14'(x);

  // Six stages of magnitude plus the indicator flop give the latency
  // seven cycle path
  always_ff @(posedge clock_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      for (int i = 0; i < PIPE; i++) mag_pipe_reg[i] <= 14'h0000;
    end else begin
      mag_pipe_reg[0] <= mag;
      for (int i = 1; i < PIPE; i++) mag_pipe_reg[i] <= mag_pipe_reg[i-1];
    end
  end

  // Thresholds and magnitude share one scale, 2^13 being full scale
  // shared magnitude scale
  assign mag_d     = mag_pipe_reg[PIPE-1];
  assign dwell_inc = {1'b0, dwell_cnt_reg} + 17'h00001;

  // Indicator with hysteresis; a dwell of zero acts as one cycle
  // low until crossing
  always_ff @(posedge clock_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      indicator_o   <= 1'b0;
      dwell_cnt_reg <= 16'h0000;
    end else if (!detect_enable_i) begin
      indicator_o   <= 1'b0;
      dwell_cnt_reg <= 16'h0000;
    end else if (mag_d > {1'b0, upper_thr_i}) begin
      indicator_o   <= 1'b1;
      dwell_cnt_reg <= 16'h0000;
    end else if (indicator_o && (mag_d < {1'b0, lower_thr_i})) begin
      if (dwell_inc >= {1'b0, dwell_i}) begin
        indicator_o   <= 1'b0;
        dwell_cnt_reg <= 16'h0000;
      end else begin
        dwell_cnt_reg <= dwell_inc[15:0];
      end
    end else begin
      dwell_cnt_reg <= 16'h0000;
    end
  end

  always_ff @(posedge clock_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      ovr_pipe_reg <= '0;
    end else begin
      ovr_pipe_reg <= {ovr_pipe_reg[OVR-2:0], overrange_i};
    end
  end

  assign overrange_o = ovr_pipe_reg[OVR-1];

  // One-pole estimator: acc moves by (x - acc) / 2^(k+14) per sample
  // high-pass corner
  assign null_shift = {1'b0, null_k_i} + adc_post_pkg::NULL_K_BASE;
  assign target     = {{6{x[13]}}, x, 28'h0000000};
  assign step       = (target - acc_reg) >>> null_shift;

  always_ff @(posedge clock_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      acc_reg <= '0;
    end else if (!null_freeze_i) begin
      acc_reg <= acc_reg + step;
    end
  end

  // 14 integer and 2 fraction bits cover the input range
  assign null_value_o = acc_reg[adc_post_pkg::NULL_FRAC+13:adc_post_pkg::NULL_FRAC-2];
  assign dc_int       = acc_reg[adc_post_pkg::NULL_FRAC+13:adc_post_pkg::NULL_FRAC];

  // Saturate rather than wrap when the correction pushes past full scale
  assign corr = {x[13], x} - {dc_int[13], dc_int};
  assign corr_sat = (corr[14] != corr[13]) ? {corr[14], {13{~corr[14]}}} : corr[13:0];

  assign out_word = null_enable_i ? corr_sat : x;

  always_ff @(posedge clock_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      data_o <= 14'h0000;
    end else begin
      data_o <= twos_comp_i ? out_word : {~out_word[13], out_word[12:0]};
    end
  end

endmodule // sample_channel

/* verilog/adc_post_top.sv */
`timescale 1ns/1ns
module adc_post_top (
  input  wire logic        clock_i,
  input  wire logic        rst_n_i,
  input  wire logic        spi_sclk_i,
  input  wire logic        spi_cs_n_i,
  input  wire logic        spi_sdio_i,
  output logic             spi_sdio_o,
  output logic             spi_sdio_oe_o,
  input  wire logic [13:0] sample_a_i,
  input  wire logic [13:0] sample_b_i,
  input  wire logic        overrange_a_i,
  input  wire logic        overrange_b_i,
  output logic      [13:0] data_a_o,
  output logic      [13:0] data_b_o,
  output logic             overrange_a_o,
  output logic             overrange_b_o,
  output logic             threshold_indicator_chan_a_o,
  output logic             threshold_indicator_chan_b_o
);

  // ----------------------------------------------------------------
  // Declarations
  // ----------------------------------------------------------------

  logic                     sclk_meta_reg;
  logic                     sclk_sync_reg;
  logic                     sclk_prev_reg;
  logic                     cs_meta_reg;
  logic                     cs_sync_reg;
  logic                     sdio_meta_reg;
  logic                     sdio_sync_reg;
  logic                     sclk_rise;
  logic                     sclk_fall;
  logic                     frame_active;

  adc_post_pkg::spi_state_t state_reg;
  logic              [15:0] instr_shift_reg;
  logic               [3:0] bit_cnt_reg;
  logic               [7:0] rx_shift_reg;
  logic               [7:0] tx_shift_reg;
  logic                     read_reg;
  logic               [1:0] width_reg;
  logic               [1:0] bytes_left_reg;
  logic              [12:0] addr_reg;
  logic                     wr_en;
  logic               [7:0] wr_data;
  logic               [7:0] rd_data;

  logic               [7:0] chan_index_reg;
  logic               [7:0] out_format_reg;
  logic               [7:0] null_ctrl_reg;
  logic               [7:0] detect_ctrl_reg;
  logic              [15:0] upper_thr_reg;
  logic              [15:0] lower_thr_reg;
  logic              [15:0] dwell_reg;

  logic              [15:0] null_value_a;
  logic              [15:0] null_value_b;
  logic              [15:0] null_value_sel;

  // ----------------------------------------------------------------
  // Pin synchronisers
  // ----------------------------------------------------------------

  // Serial pins are asynchronous to the sample clock, so two flops each;
  // the serial clock must stay below a quarter of clock_i
  always_ff @(posedge clock_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      sclk_meta_reg <= 1'b0;
      sclk_sync_reg <= 1'b0;
      sclk_prev_reg <= 1'b0;
      cs_meta_reg   <= 1'b1;
      cs_sync_reg   <= 1'b1;
      sdio_meta_reg <= 1'b0;
      sdio_sync_reg <= 1'b0;
    end else begin
      sclk_meta_reg <= spi_sclk_i;
      sclk_sync_reg <= sclk_meta_reg;
      sclk_prev_reg <= sclk_sync_reg;
      cs_meta_reg   <= spi_cs_n_i;
      cs_sync_reg   <= cs_meta_reg;
      sdio_meta_reg <= spi_sdio_i;
      sdio_sync_reg <= sdio_meta_reg;
    end
  end

  // Edge detection reads only the settled copies
  assign frame_active = !cs_sync_reg;
  assign sclk_rise    = frame_active && sclk_sync_reg && !sclk_prev_reg;
  assign sclk_fall    = frame_active && !sclk_sync_reg && sclk_prev_reg;

  // ----------------------------------------------------------------
  // Serial frame engine
  // ----------------------------------------------------------------

  // Instruction: read flag, two length bits, 13-bit address, MSB first.
  // Length code 3 streams until chip select rises.
  always_ff @(posedge clock_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      state_reg       <= adc_post_pkg::SPI_INSTR;
      instr_shift_reg <= 16'h0000;
      bit_cnt_reg     <= 4'h0;
      rx_shift_reg    <= 8'h00;
      read_reg        <= 1'b0;
      width_reg       <= 2'h0;
      bytes_left_reg  <= 2'h0;
      addr_reg        <= 13'h0000;
    end else if (!frame_active) begin
      state_reg   <= adc_post_pkg::SPI_INSTR;
      bit_cnt_reg <= 4'h0;
    end else if (sclk_rise) begin
      case (state_reg)
        adc_post_pkg::SPI_INSTR: begin
          instr_shift_reg <= {instr_shift_reg[14:0], sdio_sync_reg};
          bit_cnt_reg     <= bit_cnt_reg + 4'h1;
          if (bit_cnt_reg == 4'(adc_post_pkg::INSTR_BITS - 1)) begin
            state_reg      <= adc_post_pkg::SPI_DATA;
            bit_cnt_reg    <= 4'h0;
            read_reg       <= instr_shift_reg[14];
            width_reg      <= instr_shift_reg[13:12];
            bytes_left_reg <= instr_shift_reg[13:12];
            addr_reg       <= {instr_shift_reg[11:0], sdio_sync_reg};
          end
        end
        adc_post_pkg::SPI_DATA: begin
          rx_shift_reg <= {rx_shift_reg[6:0], sdio_sync_reg};
          bit_cnt_reg  <= bit_cnt_reg + 4'h1;
          if (bit_cnt_reg == 4'h7) begin
            // Address walks downward between bytes
            bit_cnt_reg    <= 4'h0;
            addr_reg       <= addr_reg - 13'h0001;
            bytes_left_reg <= bytes_left_reg - 2'h1;
            if (width_reg != 2'h3 && bytes_left_reg == 2'h0) begin
              state_reg <= adc_post_pkg::SPI_DONE;
            end
          end
        end
        default: begin
          // Extra clocks after the last byte are ignored
          bit_cnt_reg <= 4'h0;
        end
      endcase
    end
  end

  // A byte is written on the rising edge that completes it
  assign wr_en   = sclk_rise && !read_reg && state_reg == adc_post_pkg::SPI_DATA
                   && bit_cnt_reg == 4'h7;
  assign wr_data = {rx_shift_reg[6:0], sdio_sync_reg};

  // Readback shifts out on falling edges so the master samples on rising
  always_ff @(posedge clock_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      tx_shift_reg  <= 8'h00;
      spi_sdio_o    <= 1'b0;
    end else if (sclk_fall && read_reg && state_reg == adc_post_pkg::SPI_DATA) begin
      if (bit_cnt_reg == 4'h0) begin
        spi_sdio_o   <= rd_data[7];
        tx_shift_reg <= {rd_data[6:0], 1'b0};
      end else begin
        spi_sdio_o   <= tx_shift_reg[7];
        tx_shift_reg <= {tx_shift_reg[6:0], 1'b0};
      end
    end
  end

  // Pin is driven only in the data phase of a read frame
  assign spi_sdio_oe_o = frame_active && read_reg && state_reg == adc_post_pkg::SPI_DATA;

  // ----------------------------------------------------------------
  // Register file
  // ----------------------------------------------------------------

  // Control bytes shared by both channels
  always_ff @(posedge clock_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      chan_index_reg  <= adc_post_pkg::RST_CHAN_INDEX;
      out_format_reg  <= adc_post_pkg::RST_OUT_FORMAT;
      null_ctrl_reg   <= adc_post_pkg::RST_ZERO;
      detect_ctrl_reg <= adc_post_pkg::RST_ZERO;
    end else if (wr_en) begin
      if (addr_reg == adc_post_pkg::ADDR_CHAN_INDEX) begin
        chan_index_reg <= wr_data;
      end else if (addr_reg == adc_post_pkg::ADDR_OUT_FORMAT) begin
        out_format_reg <= wr_data;
      end else if (addr_reg == adc_post_pkg::ADDR_NULL_CTRL) begin
        null_ctrl_reg <= wr_data;
      end else if (addr_reg == adc_post_pkg::ADDR_DETECT_CTRL) begin
        detect_ctrl_reg <= wr_data;
      end
    end
  end

  // Threshold and dwell byte pairs; threshold high bytes keep 5 bits
  always_ff @(posedge clock_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      upper_thr_reg <= 16'h0000;
      lower_thr_reg <= 16'h0000;
      dwell_reg     <= 16'h0000;
    end else if (wr_en) begin
      if (addr_reg == adc_post_pkg::ADDR_UPPER_LO) begin
        upper_thr_reg[7:0] <= wr_data;
      end else if (addr_reg == adc_post_pkg::ADDR_UPPER_HI) begin
        upper_thr_reg[15:8] <= {3'h0, wr_data[4:0]};
      end else if (addr_reg == adc_post_pkg::ADDR_LOWER_LO) begin
        lower_thr_reg[7:0] <= wr_data;
      end else if (addr_reg == adc_post_pkg::ADDR_LOWER_HI) begin
        lower_thr_reg[15:8] <= {3'h0, wr_data[4:0]};
      end else if (addr_reg == adc_post_pkg::ADDR_DWELL_LO) begin
        dwell_reg[7:0] <= wr_data;
      end else if (addr_reg == adc_post_pkg::ADDR_DWELL_HI) begin
        dwell_reg[15:8] <= wr_data;
      end
    end
  end

  // Nulling readback follows channel B only when A is deselected
  assign null_value_sel = (chan_index_reg[adc_post_pkg::CHAN_B_BIT] && !chan_index_reg[0])
                          ? null_value_b : null_value_a;

  // Read decode; unmapped addresses read as zero
  always_comb begin
    rd_data = 8'h00;
    if (addr_reg == adc_post_pkg::ADDR_CHAN_INDEX) begin
      rd_data = chan_index_reg;
    end else if (addr_reg == adc_post_pkg::ADDR_OUT_FORMAT) begin
      rd_data = out_format_reg;
    end else if (addr_reg == adc_post_pkg::ADDR_NULL_CTRL) begin
      rd_data = null_ctrl_reg;
    end else if (addr_reg == adc_post_pkg::ADDR_NULL_VAL_LO) begin
      rd_data = null_value_sel[7:0];
    end else if (addr_reg == adc_post_pkg::ADDR_NULL_VAL_HI) begin
      rd_data = null_value_sel[15:8];
    end else if (addr_reg == adc_post_pkg::ADDR_DETECT_CTRL) begin
      rd_data = detect_ctrl_reg;
    end else if (addr_reg == adc_post_pkg::ADDR_UPPER_LO) begin
      rd_data = upper_thr_reg[7:0];
    end else if (addr_reg == adc_post_pkg::ADDR_UPPER_HI) begin
      rd_data = upper_thr_reg[15:8];
    end else if (addr_reg == adc_post_pkg::ADDR_LOWER_LO) begin
      rd_data = lower_thr_reg[7:0];
    end else if (addr_reg == adc_post_pkg::ADDR_LOWER_HI) begin
      rd_data = lower_thr_reg[15:8];
    end else if (addr_reg == adc_post_pkg::ADDR_DWELL_LO) begin
      rd_data = dwell_reg[7:0];
    end else if (addr_reg == adc_post_pkg::ADDR_DWELL_HI) begin
      rd_data = dwell_reg[15:8];
    end
  end

  // ----------------------------------------------------------------
  // Channels
  // ----------------------------------------------------------------

  sample_channel u_chan_a (
    .clock_i         (clock_i),
    .rst_n_i         (rst_n_i),
    .sample_i        (sample_a_i),
    .overrange_i     (overrange_a_i),
    .detect_enable_i (detect_ctrl_reg[adc_post_pkg::DETECT_EN_BIT]),
    .upper_thr_i     (upper_thr_reg[12:0]),
    .lower_thr_i     (lower_thr_reg[12:0]),
    .dwell_i         (dwell_reg),
    .null_enable_i   (null_ctrl_reg[adc_post_pkg::NULL_EN_BIT]),
    .null_freeze_i   (null_ctrl_reg[adc_post_pkg::NULL_FREEZE_BIT]),
    .null_k_i        (null_ctrl_reg[adc_post_pkg::NULL_K_MSB:adc_post_pkg::NULL_K_LSB]),
    .twos_comp_i     (out_format_reg[adc_post_pkg::FORMAT_TWOS_BIT]),
    .data_o          (data_a_o),
    .overrange_o     (overrange_a_o),
    .indicator_o     (threshold_indicator_chan_a_o),
    .null_value_o    (null_value_a)
  );

  sample_channel u_chan_b (
    .clock_i         (clock_i),
    .rst_n_i         (rst_n_i),
    .sample_i        (sample_b_i),
    .overrange_i     (overrange_b_i),
    .detect_enable_i (detect_ctrl_reg[adc_post_pkg::DETECT_EN_BIT]),
    .upper_thr_i     (upper_thr_reg[12:0]),
    .lower_thr_i     (lower_thr_reg[12:0]),
    .dwell_i         (dwell_reg),
    .null_enable_i   (null_ctrl_reg[adc_post_pkg::NULL_EN_BIT]),
    .null_freeze_i   (null_ctrl_reg[adc_post_pkg::NULL_FREEZE_BIT]),
    .null_k_i        (null_ctrl_reg[adc_post_pkg::NULL_K_MSB:adc_post_pkg::NULL_K_LSB]),
    .twos_comp_i     (out_format_reg[adc_post_pkg::FORMAT_TWOS_BIT]),
    .data_o          (data_b_o),
    .overrange_o     (overrange_b_o),
    .indicator_o     (threshold_indicator_chan_b_o),
    .null_value_o    (null_value_b)
  );

endmodule // adc_post_top

/* test/adc_post_checker.sv */
`timescale 1ns/1ns
module adc_post_checker (
  input  wire logic        clock_i,
  input  wire logic        rst_n_i,
  input  wire logic        spi_cs_n_i,
  input  wire logic        spi_sdio_oe_o,
  input  wire logic [13:0] sample_a_i,
  input  wire logic [13:0] sample_b_i,
  input  wire logic        overrange_a_i,
  input  wire logic        overrange_b_i,
  input  wire logic        overrange_a_o,
  input  wire logic        overrange_b_o,
  input  wire logic        threshold_indicator_chan_a_o,
  input  wire logic        threshold_indicator_chan_b_o
);
  // ----------------------------------------
  // Port relations, one clock domain
  // ----------------------------------------
  default clocking @(posedge clock_i); endclocking
  default disable iff (!rst_n_i);

  // Overrange history only means something once the delay line has refilled
  logic [5:0] warm_cnt_reg;
  always_ff @(posedge clock_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      warm_cnt_reg <= 6'h00;
    end else if (warm_cnt_reg != 6'h24) begin
      warm_cnt_reg <= warm_cnt_reg + 6'h01;
    end
  end

  property p_ovr_a;
    (warm_cnt_reg == 6'h24) |-> overrange_a_o == $past(overrange_a_i, 36); endproperty
  a_ovr_a: assert property (p_ovr_a) else $error("overrange a delay wrong");
  property p_ovr_b;
    (warm_cnt_reg == 6'h24) |-> overrange_b_o == $past(overrange_b_i, 36); endproperty
  a_ovr_b: assert property (p_ovr_b) else $error("overrange b delay wrong");
  // A rise needs a nonzero sample seven cycles upstream of the update
  property p_rise_a;
    $rose(threshold_indicator_chan_a_o) |-> $past(sample_a_i, 7) != 14'h0000; endproperty
  a_rise_a: assert property (p_rise_a) else $error("indicator a rose without cause");
  property p_rise_b;
    $rose(threshold_indicator_chan_b_o) |-> $past(sample_b_i, 7) != 14'h0000; endproperty
  a_rise_b: assert property (p_rise_b) else $error("indicator b rose without cause");
  property p_quiet_a;
    !threshold_indicator_chan_a_o && $past(sample_a_i, 6) == 14'h0000
      |=> !threshold_indicator_chan_a_o; endproperty
  a_quiet_a: assert property (p_quiet_a) else $error("indicator a rose on zero");
  // Magnitude 8192 is never below any 13-bit lower threshold
  property p_fall_a;
    $fell(threshold_indicator_chan_a_o) |-> $past(sample_a_i, 7) != 14'h2000; endproperty
  a_fall_a: assert property (p_fall_a) else $error("indicator a fell on full scale");
  property p_fall_b;
    $fell(threshold_indicator_chan_b_o) |-> $past(sample_b_i, 7) != 14'h2000; endproperty
  a_fall_b: assert property (p_fall_b) else $error("indicator b fell on full scale");
  property p_oe_cs;
    spi_sdio_oe_o |-> !$past(spi_cs_n_i, 2); endproperty
  a_oe_cs: assert property (p_oe_cs) else $error("sdio driven outside frame");
endmodule // adc_post_checker

bind adc_post_top adc_post_checker u_chk (
  .clock_i(clock_i), .rst_n_i(rst_n_i), .spi_cs_n_i(spi_cs_n_i),
  .spi_sdio_oe_o(spi_sdio_oe_o), .sample_a_i(sample_a_i), .sample_b_i(sample_b_i),
  .overrange_a_i(overrange_a_i), .overrange_b_i(overrange_b_i),
  .overrange_a_o(overrange_a_o), .overrange_b_o(overrange_b_o),
  .threshold_indicator_chan_a_o(threshold_indicator_chan_a_o),
  .threshold_indicator_chan_b_o(threshold_indicator_chan_b_o));

/* test/gain_monitor.sv */
`timescale 1ns/1ns
module gain_monitor (
  input  wire logic       clock_i,
  input  wire logic       rst_n_i,
  input  wire logic       ind_a_i,
  input  wire logic       ind_b_i,
  output logic      [7:0] rise_a_o,
  output logic      [7:0] rise_b_o
);
  logic prev_a_reg;
  logic prev_b_reg;
  // Count attenuator insertions; wraps at 255, enough for short runs
  always_ff @(posedge clock_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      prev_a_reg <= 1'b0;
      prev_b_reg <= 1'b0;
      rise_a_o   <= 8'h00;
      rise_b_o   <= 8'h00;
    end else begin
      prev_a_reg <= ind_a_i;
      prev_b_reg <= ind_b_i;
      if (ind_a_i && !prev_a_reg) rise_a_o <= rise_a_o + 8'h01;
      if (ind_b_i && !prev_b_reg) rise_b_o <= rise_b_o + 8'h01;
    end
  end
endmodule // gain_monitor

/* test/tb_top.sv */
`timescale 1ns/1ns
module tb_top;
  logic        clock_i = 1'b0;
  logic        rst_n_i = 1'b0;
  logic        sclk    = 1'b0;
  logic        cs_n    = 1'b1;
  logic        mosi    = 1'b0;
  logic        ovr_a   = 1'b0;
  logic        ovr_b   = 1'b0;
  logic [13:0] smp_a   = 14'h0000;
  logic [13:0] smp_b   = 14'h0FA0;
  logic [7:0]  rd;
  logic [7:0]  v1;
  logic [13:0] d1;
  wire         sdio_o, sdio_oe, ov_a, ov_b, ind_a, ind_b;
  wire  [13:0] dat_a, dat_b;
  wire  [7:0]  rise_a, rise_b;
  wire         sdio    = sdio_oe ? sdio_o : mosi;
  int          err_total    = 0;
  int          total_checks = 0;
  logic [12:0] ra [5]  = '{13'h0014, 13'h0040, 13'h0045, 13'h004B, 13'h0013};
  logic [7:0]  rv [5]  = '{8'h01, 8'h00, 8'h00, 8'h00, 8'h00};
  logic [13:0] tv [3]  = '{14'h2FFF, 14'h1001, 14'h1000};
  logic        te [3]  = '{1'b1, 1'b1, 1'b0};

  adc_post_top DUT (.clock_i(clock_i), .rst_n_i(rst_n_i), .spi_sclk_i(sclk),
    .spi_cs_n_i(cs_n), .spi_sdio_i(sdio), .spi_sdio_o(sdio_o), .spi_sdio_oe_o(sdio_oe),
    .sample_a_i(smp_a), .sample_b_i(smp_b), .overrange_a_i(ovr_a), .overrange_b_i(ovr_b),
    .data_a_o(dat_a), .data_b_o(dat_b), .overrange_a_o(ov_a), .overrange_b_o(ov_b),
    .threshold_indicator_chan_a_o(ind_a), .threshold_indicator_chan_b_o(ind_b));
  gain_monitor u_mon (.clock_i(clock_i), .rst_n_i(rst_n_i), .ind_a_i(ind_a),
    .ind_b_i(ind_b), .rise_a_o(rise_a), .rise_b_o(rise_b));

  initial forever #20 clock_i = ~clock_i;

  // ----------------------------------------
  // Serial port and compare helpers
  // ----------------------------------------
  task automatic tick(input int n); repeat (n) @(negedge clock_i); endtask
  // Eight clocks per sclk phase keeps the two-flop synchroniser safe
  task automatic spi(input logic rw, input logic [12:0] a, input logic [7:0] d);
    logic [23:0] w;
    w = {rw, 2'b00, a, d};
    cs_n = 1'b0;
    tick(8);
    for (int i = 23; i >= 0; i--) begin
      mosi = w[i];
      tick(8);
      rd = {rd[6:0], sdio};
      sclk = 1'b1;
      tick(8);
      sclk = 1'b0;
    end
    tick(8);
    cs_n = 1'b1;
    tick(8);
  endtask
  task automatic chk(input logic [15:0] seen, input logic [15:0] exp, input string nm);
    total_checks++;
    if (seen !== exp) begin
      err_total++;
      $display("mismatch %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task automatic rdc(input logic [12:0] a, input logic [7:0] exp);
    spi(1'b1, a, 8'h00);
    chk(rd, exp, "register");
  endtask
  task automatic end_sim();
    $display("checks %0d mismatches %0d", total_checks, err_total);
    if (err_total == 0 && total_checks > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask

  // ----------------------------------------
  // Test sequence
  // ----------------------------------------
  initial begin
    tick(5);
    rst_n_i = 1'b1;
    tick(4);
    foreach (ra[i]) rdc(ra[i], rv[i]);
    spi(1'b0, 13'h0041, 8'hA5);
    rdc(13'h0041, 8'h00);
    smp_a = 14'h0064;
    tick(2);
    chk(dat_a, 14'h0064, "twos output");
    chk(dat_b, 14'h0FA0, "channel b data");
    spi(1'b0, 13'h0014, 8'h00);
    chk(dat_a, 14'h2064, "offset binary");
    spi(1'b0, 13'h0014, 8'h01);
    $display("test registers and format done");
    smp_a = 14'h0000;
    // Upper 4096, lower 2048, dwell 4
    spi(1'b0, 13'h0048, 8'h10);
    spi(1'b0, 13'h004A, 8'h08);
    spi(1'b0, 13'h004B, 8'h04);
    spi(1'b0, 13'h0045, 8'h01);
    for (int i = 0; i < 3; i++) begin
      smp_a = tv[i];
      tick(1);
      smp_a = 14'h0000;
      tick(2);
      smp_a = 14'h0BB8;
      tick(1);
      smp_a = 14'h0000;
      tick(2);
      chk(ind_a, 1'b0, "before latency");
      tick(1);
      chk(ind_a, te[i], "after latency");
      tick(6);
      chk(ind_a, te[i], "dwell restarted");
      tick(1);
      chk(ind_a, 1'b0, "dwell cleared");
      chk(ind_b, 1'b0, "other channel");
    end
    chk(rise_a, 8'h02, "rises a");
    chk(rise_b, 8'h00, "rises b");
    // Most negative sample on B; 4000 afterwards sits between the thresholds
    smp_b = 14'h2000;
    tick(1);
    smp_b = 14'h0FA0;
    tick(8);
    chk(ind_b, 1'b1, "b negative full scale");
    spi(1'b0, 13'h0045, 8'h00);
    smp_a = 14'h1F40;
    tick(10);
    chk(ind_a, 1'b0, "detect off");
    $display("test threshold detect done");
    ovr_a = 1'b1;
    tick(1);
    ovr_a = 1'b0;
    tick(1);
    ovr_b = 1'b1;
    tick(1);
    ovr_b = 1'b0;
    tick(33);
    chk({ov_a, ov_b}, 2'b10, "overrange a");
    tick(2);
    chk({ov_a, ov_b}, 2'b01, "overrange b");
    $display("test overrange done");
    smp_a = 14'h0190;
    // k kept within 0..13 by software
    spi(1'b0, 13'h0040, 8'h02);
    tick(2000);
    chk(dat_a < 14'h0190, 1'b1, "corrected data");
    spi(1'b0, 13'h0040, 8'h42);
    spi(1'b1, 13'h0041, 8'h00);
    v1 = rd;
    d1 = dat_a;
    chk(v1 != 8'h00, 1'b1, "value nonzero");
    tick(500);
    rdc(13'h0041, v1);
    chk(dat_a, d1, "frozen data");
    spi(1'b0, 13'h0040, 8'h02);
    tick(500);
    spi(1'b1, 13'h0041, 8'h00);
    chk(rd != v1, 1'b1, "resumed value");
    spi(1'b0, 13'h0040, 8'h34);
    rdc(13'h0040, 8'h34);
    chk(dat_a, 14'h0190, "correction off");
    $display("test offset nulling done");
    end_sim();
  end

  // Watchdog sized well beyond the expected run of about 12000 cycles
  initial begin
    #2000000;
    err_total++;
    end_sim();
  end
endmodule // tb_top
